// file: sbmc_pkg.sv
// Package for the system bus master control block: timing constants,
// pin group structs and decode codes.
// Assumes a 100 MHz pclk.
package sbmc_pkg;

	// ---------------------------------------------
	// Timing
	// ---------------------------------------------
	localparam int CLK_PERIOD_NS    = 10;
	localparam int TIMEOUT_US       = 22;
	localparam int INIT_DELAY_US    = 2;
	localparam int AUX_PULSE_NS     = 300;
	// Longest times round down, least times round up
	localparam int TIMEOUT_CYCLES   = (TIMEOUT_US * 1000) / CLK_PERIOD_NS;
	localparam int INIT_CYCLES      = (INIT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AUX_CYCLES       = (AUX_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W            = 16;

	// ---------------------------------------------
	// Microbranch decode
	// ---------------------------------------------
	localparam int ACK_CODE_W       = 4;
	localparam int ACK_STROBES      = 16;
	localparam int ACK_USED         = 5;

	// ---------------------------------------------
	// APB status/control
	// ---------------------------------------------
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam int CTRL_MASTER      = 0;
	localparam int CTRL_MANUAL      = 1;
	localparam int ST_BUSY          = 0;
	localparam int ST_HOLD          = 1;
	localparam int ST_TIMEOUT       = 2;
	localparam int ST_GRANT         = 3;
	localparam int ST_AUX           = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

	// Bus pins seen by the block (inputs, already active high)
	typedef struct packed {
		logic bus_busy;
		logic np_grant;
		logic sel_ack;
		logic slave_sync;
		logic np_request;
		logic [3:0] bus_request;
	} sbmc_bus_in_t;

	// Bus pins driven by the block (active high, enable outside)
	typedef struct packed {
		logic assert_bus_busy;
		logic master_sync_out;
		logic bus_init;
		logic bus_error;
	} sbmc_bus_out_t;

	typedef enum logic [2:0] {
		XF_IDLE = 3'b001,
		XF_SYNC = 3'b010,
		XF_DONE = 3'b100
	} sbmc_xfer_t;

	typedef enum logic [2:0] {
		IN_IDLE = 3'b001,
		IN_WAIT = 3'b010,
		IN_INIT = 3'b100
	} sbmc_init_t;

endpackage : sbmc_pkg

// file: sbmc_top.sv
// System bus master control: busy hold, slave take-over, sync timeout,
// init delay, interrupt-ack decode, aux enable pulse and clock gating.
// Assumes bus pins are active high here; pads invert and drive outside.
//
// Summary of operation
// - Bus busy held through read-pause transfer
// - Hold flag drives busy, master or slave
// - Hold flag blocks grant flag when master
// - Slave keeps busy asserted until take-bus drops
// - Take-bus qualifies busy flag set input
// - Busy flag drives assert-busy output
// - Slave sync drops master sync on writes
// - Master sync starts 22 us timeout
// - Timeout flag feeds bus error
// - Maintenance stops clock, allows single step
// - Timeout unaffected by maintenance mode
// - Four-bit code to five strobes, enabled low
// - Aux enable pulse 300 ns wide
// - Aux enable early, clock keeps running
// - Aux request sets flag next edge
// - Aux entry also during move-byte
// - Bus init about 2 us after strobe
// - Busy, grant or select-ack block init
// - Console start enables processor clock
// - Slave ignores other requests
// - Slave never drives bus init
`timescale 1ns/1ns
module sbmc_top #(
	parameter int TIMEOUT_CYCLES = sbmc_pkg::TIMEOUT_CYCLES
) (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// System bus pins
	input  sbmc_pkg::sbmc_bus_in_t     bus_in,
	output sbmc_pkg::sbmc_bus_out_t    bus_out,
	// Processor side
	input  wire logic                  xfer_start,
	input  wire logic                  xfer_write,
	input  wire logic                  xfer_readpause,
	input  wire logic                  slave_take_bus,
	input  wire logic                  np_grant_in,
	output logic                       xfer_done,
	output logic                       np_grant_flag,
	output logic                       request_seen,
	// Microbranch and aux control
	input  wire logic                  service_branch_enable,
	input  wire logic [3:0]            intr_ack_lookup,
	output logic      [4:0]            intr_ack_strobe,
	input  wire logic                  aux_control_request,
	input  wire logic                  move_byte,
	output logic                       aux_control_enable,
	input  wire logic                  init_branch_strobe,
	// Clock control
	input  wire logic                  console_start,
	input  wire logic                  clock_stop_request,
	input  wire logic                  single_step,
	output logic                       processor_clock_ungated
);

	// ---------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------
	localparam int NSYNC = 10;
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	wire  [NSYNC-1:0] raw_in = {bus_in.bus_busy, bus_in.np_grant, bus_in.sel_ack,
		bus_in.slave_sync, bus_in.np_request, bus_in.bus_request, console_start};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= raw_in;
			sync2 <= sync1;
		end
	end

	wire s_busy      = sync2[9];
	wire s_grant     = sync2[8];
	wire s_sack      = sync2[7];
	wire any_slave_sync = sync2[6];
	wire s_npr       = sync2[5];
	wire [3:0] s_br  = sync2[4:1];
	wire s_start     = sync2[0];

	// ---------------------------------------------
	// APB registers
	// ---------------------------------------------
	logic [31:0] ctrl;
	wire  wr_en     = psel && penable && pwrite;
	wire  hit_ctrl  = paddr == sbmc_pkg::REG_CTRL;
	wire  hit_stat  = paddr == sbmc_pkg::REG_STATUS;
	wire  master_select       = ctrl[sbmc_pkg::CTRL_MASTER];
	wire  manual_clock_select = ctrl[sbmc_pkg::CTRL_MANUAL];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl <= sbmc_pkg::CTRL_RESET;
		else if (wr_en && hit_ctrl)
			ctrl <= {30'h0000_0000, pwdata[1:0]};
	end

	logic readpause_hold_flag;
	logic bus_busy_flag;
	logic transfer_timeout_flag;
	logic [31:0] status;
	assign status = {27'h0000000, aux_control_enable, np_grant_flag,
		transfer_timeout_flag, readpause_hold_flag, bus_busy_flag};
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !(hit_ctrl || hit_stat);
	assign prdata  = hit_ctrl ? ctrl : (hit_stat ? status : 32'h0000_0000);

	// ---------------------------------------------
	// Transfer sequencing
	// ---------------------------------------------
	sbmc_pkg::sbmc_xfer_t xf;
	sbmc_pkg::sbmc_xfer_t next_xf;
	logic write_cycle_flag;
	logic [sbmc_pkg::CNT_W-1:0] to_cnt;
	logic to_run;

	wire sync_end = any_slave_sync || (to_run && to_cnt == '0);

	always_comb
	begin
		next_xf = xf;
		unique case (xf)
			sbmc_pkg::XF_IDLE: if (xfer_start) next_xf = sbmc_pkg::XF_SYNC;
			sbmc_pkg::XF_SYNC: if (sync_end) next_xf = sbmc_pkg::XF_DONE;
			sbmc_pkg::XF_DONE: if (!any_slave_sync) next_xf = sbmc_pkg::XF_IDLE;
			default:           next_xf = sbmc_pkg::XF_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			xf               <= sbmc_pkg::XF_IDLE;
			write_cycle_flag <= 1'b0;
		end
		else
		begin
			xf <= next_xf;
			if (xf == sbmc_pkg::XF_IDLE && xfer_start)
				write_cycle_flag <= xfer_write;
		end
	end

	// Write drops sync combinationally the moment synchronised slave sync returns
	assign bus_out.master_sync_out = (xf == sbmc_pkg::XF_SYNC) &&
		!(write_cycle_flag && any_slave_sync);
	assign xfer_done = (xf == sbmc_pkg::XF_DONE) && !any_slave_sync;

	// ---------------------------------------------
	// Timeout: no manual-clock term, so it works in single step
	// ---------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			to_cnt <= '0;
			to_run <= 1'b0;
			transfer_timeout_flag <= 1'b0;
		end
		else
		begin
			if (xf == sbmc_pkg::XF_IDLE && xfer_start)
			begin
				to_cnt <= sbmc_pkg::CNT_W'(TIMEOUT_CYCLES - 1);
				to_run <= 1'b1;
			end
			// Answered transfer stops the timer, so sync gone later is no timeout
			else if (to_run && to_cnt != '0 && xf == sbmc_pkg::XF_SYNC)
				to_cnt <= to_cnt - 1'b1;
			else
				to_run <= 1'b0;
			if (to_run && to_cnt == '0 && xf == sbmc_pkg::XF_SYNC)
				transfer_timeout_flag <= !any_slave_sync;
			else if (xf == sbmc_pkg::XF_IDLE && xfer_start)
				transfer_timeout_flag <= 1'b0;
		end
	end
	assign bus_out.bus_error = transfer_timeout_flag;

	// ---------------------------------------------
	// Busy, hold and grant
	// ---------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			readpause_hold_flag <= 1'b0;
			bus_busy_flag       <= 1'b0;
			np_grant_flag       <= 1'b0;
		end
		else
		begin
			// Held from read-pause start until its write finishes
			if (xf == sbmc_pkg::XF_IDLE && xfer_start && xfer_readpause)
				readpause_hold_flag <= 1'b1;
			else if (xfer_done && write_cycle_flag)
				readpause_hold_flag <= 1'b0;
			// Slave sets busy on next clock after take-bus
			if (!master_select && slave_take_bus && !s_busy)
				bus_busy_flag <= 1'b1;
			else if (!slave_take_bus)
				bus_busy_flag <= 1'b0;
			if (master_select && np_grant_in && !readpause_hold_flag)
				np_grant_flag <= 1'b1;
			else if (!np_grant_in)
				np_grant_flag <= 1'b0;
		end
	end
	assign bus_out.assert_bus_busy = bus_busy_flag || readpause_hold_flag;

	assign request_seen = master_select && (s_npr || (|s_br));

	// ---------------------------------------------
	// Interrupt-ack microbranch decode
	// ---------------------------------------------
	function automatic logic [sbmc_pkg::ACK_STROBES-1:0] dec16(input logic [3:0] code);
		dec16 = sbmc_pkg::ACK_STROBES'(1) << code;
	endfunction : dec16

	wire [sbmc_pkg::ACK_STROBES-1:0] ack_all = service_branch_enable ?
		'0 : dec16(intr_ack_lookup);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			intr_ack_strobe <= '0;
		else
			intr_ack_strobe <= ack_all[sbmc_pkg::ACK_USED-1:0];
	end

	// ---------------------------------------------
	// Aux control enable pulse
	// ---------------------------------------------
	logic [sbmc_pkg::CNT_W-1:0] aux_cnt;
	wire  aux_d = aux_control_request || (move_byte && aux_control_request);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			aux_control_enable <= 1'b0;
			aux_cnt            <= '0;
		end
		else if (aux_d && !aux_control_enable)
		begin
			aux_control_enable <= 1'b1;
			aux_cnt <= sbmc_pkg::CNT_W'(sbmc_pkg::AUX_CYCLES - 1);
		end
		else if (aux_cnt != '0)
			aux_cnt <= aux_cnt - 1'b1;
		else
			aux_control_enable <= 1'b0;
	end

	// ---------------------------------------------
	// Reset instruction init delay
	// ---------------------------------------------
	sbmc_pkg::sbmc_init_t in_st;
	logic [sbmc_pkg::CNT_W-1:0] in_cnt;
	wire  in_block = s_busy || s_grant || s_sack;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			in_st  <= sbmc_pkg::IN_IDLE;
			in_cnt <= '0;
		end
		else
		begin
			unique case (in_st)
				sbmc_pkg::IN_IDLE:
					if (init_branch_strobe && !in_block)
					begin
						in_st  <= sbmc_pkg::IN_WAIT;
						in_cnt <= sbmc_pkg::CNT_W'(sbmc_pkg::INIT_CYCLES - 1);
					end
				sbmc_pkg::IN_WAIT:
					if (in_cnt == '0)
						in_st <= sbmc_pkg::IN_INIT;
					else
						in_cnt <= in_cnt - 1'b1;
				sbmc_pkg::IN_INIT:
					if (!init_branch_strobe)
						in_st <= sbmc_pkg::IN_IDLE;
				default: in_st <= sbmc_pkg::IN_IDLE;
			endcase
		end
	end
	assign bus_out.bus_init = master_select && (in_st == sbmc_pkg::IN_INIT);

	// ---------------------------------------------
	// Processor clock enable
	// ---------------------------------------------
	// Aux mode does not stop the clock; only console start low, stop request and manual mode do
	assign processor_clock_ungated = s_start && !clock_stop_request &&
		(!manual_clock_select || single_step);

endmodule : sbmc_top

// file: sbmc_checker.sv
// Checker on the sbmc_top ports, bound after the module.
// Assumes the far-side slave answers well inside the timeout.
`timescale 1ns/1ns
module sbmc_checker #(
	parameter int TIMEOUT_CYCLES = 20
) (
	// Clock and reset
	input wire logic               pclk,
	input wire logic               presetn,
	// Watched ports
	input sbmc_pkg::sbmc_bus_in_t  bus_in,
	input sbmc_pkg::sbmc_bus_out_t bus_out,
	input wire logic               xfer_start,
	input wire logic               xfer_write,
	input wire logic               xfer_readpause,
	input wire logic               xfer_done,
	input wire logic               np_grant_flag,
	input wire logic               service_branch_enable,
	input wire logic [4:0]         intr_ack_strobe,
	input wire logic               aux_control_request,
	input wire logic               aux_control_enable,
	input wire logic               init_branch_strobe
);
	logic [15:0] to_cnt, in_cnt;
	logic        wr_lat, rp_hold, seen;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Saturating count, so an idle bench never trips the timeout check
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			to_cnt <= 16'hFFFF;
			in_cnt <= 16'h0000;
			wr_lat <= 1'b0;
			rp_hold <= 1'b0;
			seen <= 1'b0;
		end
		else
		begin
			to_cnt <= xfer_start ? 16'h0000 : to_cnt + 16'(to_cnt != 16'hFFFF);
			in_cnt <= init_branch_strobe ? in_cnt + 16'h0001 : 16'h0000;
			wr_lat <= xfer_start ? xfer_write : wr_lat;
			rp_hold <= (xfer_start && xfer_readpause) || (rp_hold && !(xfer_done && wr_lat));
			seen <= !xfer_start && (seen || bus_in.slave_sync);
		end
	end
	a_decode_exclusive: assert property ($onehot0(intr_ack_strobe))
		else $error("ack strobes not exclusive");
	a_decode_disabled: assert property ($past(service_branch_enable) |-> !intr_ack_strobe)
		else $error("ack strobe while disabled");
	a_aux_next_edge: assert property (
		$rose(aux_control_request) && !aux_control_enable |=> aux_control_enable)
		else $error("aux enable late");
	a_write_sync_drop: assert property (
		$rose(bus_in.slave_sync) && wr_lat |-> ##[1:3] !bus_out.master_sync_out)
		else $error("master sync held after slave sync");
	a_timeout_flag: assert property (
		to_cnt == 16'(TIMEOUT_CYCLES + 4) && !seen |-> bus_out.bus_error)
		else $error("no bus error after timeout");
	a_answered_no_error: assert property (
		to_cnt == 16'(TIMEOUT_CYCLES + 4) && seen |-> !bus_out.bus_error)
		else $error("bus error on answered transfer");
	a_init_delay: assert property ($rose(bus_out.bus_init) |->
		in_cnt >= 16'(sbmc_pkg::INIT_CYCLES - 2) && in_cnt <= 16'(sbmc_pkg::INIT_CYCLES + 4))
		else $error("bus init delay wrong");
	a_readpause_busy: assert property (
		rp_hold && $past(rp_hold) |-> bus_out.assert_bus_busy)
		else $error("busy dropped in read-pause");
	a_grant_held_off: assert property ($rose(np_grant_flag) |-> !$past(rp_hold))
		else $error("grant set in read-pause");
	c_timeout: cover property ($rose(bus_out.bus_error));
	c_init: cover property ($rose(bus_out.bus_init));
	c_write_drop: cover property ($rose(bus_in.slave_sync) && wr_lat);
endmodule : sbmc_checker

bind sbmc_top sbmc_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
	.pclk, .presetn, .bus_in, .bus_out, .xfer_start, .xfer_write, .xfer_readpause,
	.xfer_done, .np_grant_flag, .service_branch_enable, .intr_ack_strobe,
	.aux_control_request, .aux_control_enable, .init_branch_strobe
);

// file: sbmc_slave_model.sv
// Bus slave model: returns slave sync dly+1 cycles after master sync.
// Assumes a terminated sync line, so a released line reads low.
`timescale 1ns/1ns
module sbmc_slave_model (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Bus side and bench controls
	input  wire logic       master_sync_out,
	input  wire logic       mute,
	input  wire logic [3:0] dly,
	output logic            slave_sync
);
	logic [3:0] cnt;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 4'h0;
			slave_sync <= 1'b0;
		end
		else if (!master_sync_out)
		begin
			cnt <= 4'h0;
			slave_sync <= 1'b0;
		end
		else if (!mute && cnt == dly)
			slave_sync <= 1'b1;
		else if (!mute)
			cnt <= cnt + 4'h1;
	end
endmodule : sbmc_slave_model

// file: sbmc_top_tb.sv
// Bench for sbmc_top: APB, transfers, busy hold, init, decode, aux, clock.
// Assumes sbmc_slave_model on the sync lines and the bound checker.
`timescale 1ns/1ns
`define CMP(e, g) begin ev = (e); n_tests++; if ((g) !== ev) begin n_fail++; \
	$display("Error t=%0t exp=%h got=%h", $time, ev, g); end end
module sbmc_top_tb;
	localparam int TO = 20;
	localparam int IC = sbmc_pkg::INIT_CYCLES;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, bb, ng, sa, npr, ss, mute, obs_v, ok;
	logic [3:0]  br, dly, intr_ack_lookup;
	logic [4:0]  intr_ack_strobe, used;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, obs, ev;
	logic        xfer_start, xfer_write, xfer_readpause, slave_take_bus, np_grant_in;
	logic        xfer_done, np_grant_flag, request_seen, service_branch_enable, move_byte;
	logic        aux_control_request, aux_control_enable, init_branch_strobe, single_step;
	logic        console_start, clock_stop_request, processor_clock_ungated;
	logic [31:0] exp_q[$];
	int          n_fail = 0;
	int          n_tests = 0;
	sbmc_pkg::sbmc_bus_in_t  bus_in;
	sbmc_pkg::sbmc_bus_out_t bus_out;
	assign bus_in = {bb, ng, sa, ss, npr, br};
	always #5 pclk = ~pclk;
	sbmc_top #(.TIMEOUT_CYCLES(TO)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .bus_in, .bus_out, .xfer_start, .xfer_write,
		.xfer_readpause, .slave_take_bus, .np_grant_in, .xfer_done, .np_grant_flag,
		.request_seen, .service_branch_enable, .intr_ack_lookup, .intr_ack_strobe,
		.aux_control_request, .move_byte, .aux_control_enable, .init_branch_strobe,
		.console_start, .clock_stop_request, .single_step, .processor_clock_ungated);
	sbmc_slave_model u_slave (.pclk, .presetn, .master_sync_out(bus_out.master_sync_out),
		.mute, .dly, .slave_sync(ss));
	task automatic wrap_up();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	task automatic timed_out();
		n_fail++;
		wrap_up();
	endtask : timed_out
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	// Result appears one edge later, where the monitor takes it
	task automatic look(input logic [31:0] e, input logic [31:0] v);
		exp_q.push_back(e);
		obs <= v;
		obs_v <= 1'b1;
		@(posedge pclk) obs_v <= 1'b0;
		@(posedge pclk);
	endtask : look
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		exp_q.push_back(32'(a != sbmc_pkg::REG_CTRL && a != sbmc_pkg::REG_STATUS));
		if (!w)
			exp_q.push_back(d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (k == 50)
			timed_out();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic xfer(input logic w, input logic rp);
		int k;
		k = 0;
		xfer_write <= w;
		xfer_readpause <= rp;
		xfer_start <= 1'b1;
		@(posedge pclk) xfer_start <= 1'b0;
		while (xfer_done !== 1'b1 && k < 500)
		begin
			@(posedge pclk);
			k++;
		end
		if (k == 500)
			timed_out();
		@(posedge pclk);
	endtask : xfer
	always @(posedge pclk)
	begin
		if (psel && penable && pready)
		begin
			`CMP(exp_q.pop_front(), pslverr)
			if (!pwrite)
				`CMP(exp_q.pop_front(), prdata)
		end
		if (obs_v)
			`CMP(exp_q.pop_front(), obs)
	end
	initial
	begin
		int i;
		int k;
		{psel, penable, pwrite, paddr, pwdata, obs, obs_v, bb, ng, sa, npr, br} = '0;
		{mute, xfer_start, xfer_write, xfer_readpause, slave_take_bus, np_grant_in} = '0;
		{intr_ack_lookup, aux_control_request, move_byte, init_branch_strobe} = '0;
		{clock_stop_request, single_step, used} = '0;
		{service_branch_enable, console_start, dly} = {2'b11, 4'h2};
		void'($urandom(32'he3fe));
		cyc(12);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, sbmc_pkg::REG_CTRL, sbmc_pkg::CTRL_RESET);
		apb(0, sbmc_pkg::REG_STATUS, 32'h0);
		apb(0, 12'h010, 32'h0);
		for (i = 0; i < 4; i++)
		begin
			dly <= 4'($urandom_range(7));
			xfer(i[0], 1'b0);
			look(32'h0, bus_out.bus_error);
		end
		xfer(1'b0, 1'b1);
		np_grant_in <= 1'b1;
		cyc(4);
		look(32'h1, bus_out.assert_bus_busy);
		look(32'h0, np_grant_flag);
		apb(0, sbmc_pkg::REG_STATUS, 32'h2);
		np_grant_in <= 1'b0;
		cyc(2);
		xfer(1'b1, 1'b0);
		cyc(2);
		look(32'h0, bus_out.assert_bus_busy);
		np_grant_in <= 1'b1;
		cyc(2);
		look(32'h1, np_grant_flag);
		np_grant_in <= 1'b0;
		apb(1, sbmc_pkg::REG_CTRL, 32'h0);
		{slave_take_bus, npr, init_branch_strobe} <= 3'h7;
		br <= 4'($urandom_range(15, 1));
		cyc(IC + 12);
		look(32'h1, bus_out.assert_bus_busy);
		apb(0, sbmc_pkg::REG_STATUS, 32'h1);
		look(32'h0, request_seen);
		look(32'h0, bus_out.bus_init);
		{slave_take_bus, init_branch_strobe} <= 2'h0;
		apb(1, sbmc_pkg::REG_CTRL, 32'h1);
		cyc(4);
		look(32'h1, request_seen);
		{npr, br} <= 5'h00;
		// Busy, grant and select-ack each block the init start
		for (i = 0; i < 4; i++)
		begin
			{bb, ng, sa} <= (i == 0) ? 3'h0 : 3'(4 >> (i - 1));
			cyc(4);
			init_branch_strobe <= 1'b1;
			cyc(IC + 10);
			look(i == 0, bus_out.bus_init);
			{bb, ng, sa, init_branch_strobe} <= 4'h0;
			cyc(4);
		end
		service_branch_enable <= 1'b0;
		for (i = 0; i < 16; i++)
		begin
			intr_ack_lookup <= i[3:0];
			cyc(2);
			used = used | intr_ack_strobe;
			look(32'h1, 32'($onehot0(intr_ack_strobe)));
		end
		look(32'h1F, used);
		service_branch_enable <= 1'b1;
		intr_ack_lookup <= 4'($urandom);
		cyc(3);
		look(32'h0, intr_ack_strobe);
		for (i = 0; i < 2; i++)
		begin
			{k, ok} = {32'h0, 1'b1};
			move_byte <= i[0];
			aux_control_request <= 1'b1;
			@(posedge pclk) aux_control_request <= 1'b0;
			repeat (40)
			begin
				@(posedge pclk);
				k += (aux_control_enable === 1'b1);
				ok &= (processor_clock_ungated === 1'b1);
			end
			look(sbmc_pkg::AUX_CYCLES, k);
			look(32'h1, ok);
		end
		console_start <= 1'b0;
		cyc(4);
		look(32'h0, processor_clock_ungated);
		console_start <= 1'b1;
		for (i = 0; i < 2; i++)
		begin
			apb(1, sbmc_pkg::REG_CTRL, i ? 32'h3 : 32'h1);
			mute <= 1'b1;
			xfer(i[0], 1'b0);
			cyc(TO + 8);
			look(32'h1, bus_out.bus_error);
			apb(0, sbmc_pkg::REG_STATUS, 32'h4);
			look(!i[0], processor_clock_ungated);
			mute <= 1'b0;
		end
		single_step <= 1'b1;
		cyc(1);
		look(32'h1, processor_clock_ungated);
		wrap_up();
	end
endmodule : sbmc_top_tb
